// ---- design/mqsf_device.sv ----
// queue device end: per-queue storage, active full and output-valid flags
// What this block and its controller do
// R1: full kept per queue, active one output
// R2: full shows new queue two edges after select
// R3: writes to new queue allowed third edge on
// R4: controller checks full before writing new queue
// R5: full flag changes only on clock edge
// R6: reads update full of any queue
// R7: full driven only when write id matches
// R8: same-device switches keep driving full flag
// R9: system shares full line, one writer
// R10: valid flag updates with output register load
// R11: last word read raises flag next read
// R12: new queue word appears three cycles later
// R13: valid flag changes only on clock edge
// R14: writes clear empty of any queue
// R15: valid flag driven only when read id matches
// R16: same-device switches keep driving valid flag
// R17: system shares valid line, one reader
// R18: six-bit read bus, queue and device fields
// R19: null queue acts as empty queue
// R20: full low means full, valid low valid
// R21: write bus mirrors read bus layout
////////////////////////////////////////////////////////////////////////////
// write port timing, counted in edges after the select edge e0
//   e0: select taken, new queue field and id match latched
//   e1: full flag still shows the old queue status
//   e2: full flag switches to the new queue status
//   e3: first write into the new queue may be taken
// the full flag is frozen on the select edge and the next one, so the
// controller sees either the old queue or the new one, never a
// half-way value in between
//
// read port timing, counted the same way
//   e0: select taken, old queue kept as the draining queue
//   e1: old queue may still fall through to the output register
//   e2: old queue may still fall through to the output register
//   e3: new queue's first word and its validity are loaded
// if the new queue is empty or null at e3, the last word stays in
// the output register and the valid flag goes to invalid
//
// reset leaves the read port on the null queue, so no word falls
// through until software picks a real queue; without this, queue 0
// would be read behind the controller's back after reset
//
// limitation: a second read select inside the three-edge switch
// takes the queue field of the first select as the draining queue,
// so words of an earlier queue are not drained any further
//
// the flag drive enables are plain levels; the pads that turn them
// into a shared tri-state line live outside this block
////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module mqsf_device
  import mqsf_pkg::*;
#(
  parameter int NQ    = NUM_QUEUES,
  parameter int DEPTH = QUEUE_DEPTH
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic [2:0]   device_id_bit,   // {bit2,bit1,bit0}, static straps
  mqsf_if.device            lnk
);
  import mqsf_pkg::*;

  typedef struct packed {
    logic [NQ-1:0][DEPTH-1:0][DATA_W-1:0] mem;
    logic [NQ-1:0][PTR_W-1:0] wp;
    logic [NQ-1:0][PTR_W-1:0] rp;
    logic [NQ-1:0][CNT_W-1:0] cnt;
    logic [QSEL_W-1:0] wq;        // active write queue
    logic [1:0]        wdly;      // cycles since write select
    logic              wsel_me;
    logic [QSEL_W-1:0] rq;        // active read queue
    logic              rnull;
    logic [QSEL_W-1:0] prq;       // queue drained during a read switch
    logic              prnull;    // draining queue was the null queue
    logic              rnew;      // next edge hands over to the new queue
    logic [1:0]        rdly;      // cycles since read select
    logic              rsel_me;
    logic [DATA_W-1:0] dout;
    logic              full_n;
    logic              oval_n;
    logic              wrdy;
  } mqsf_dev_st_t;

  mqsf_dev_st_t s_q, s_d;

  // id compare of the upper select field, used on both ports
  function automatic logic id_match(input logic [SEL_W-1:0] sel,
                                    input logic [2:0] id);
    return sel[DEVID_LSB +: DEVID_W] == id;   // [R18] [R21]
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic              do_wr;
    logic              do_rd;
    logic [QSEL_W-1:0] fq;
    logic              wfull;
    logic              rempty;
    s_d   = s_q;
    // write-port select: queue field latched, write window closed for 3 edges
    if (lnk.wr_sel_strobe) begin
      s_d.wq      = lnk.write_queue_select_bus[QSEL_LSB +: QSEL_W];
      s_d.wsel_me = id_match(lnk.write_queue_select_bus, device_id_bit); // [R7]
      s_d.wdly    = 2'd0;
    end else if (s_q.wdly != 2'(WR_OPEN_LAT - 1)) begin
      s_d.wdly = s_q.wdly + 2'd1;
    end
    // writes only when window open, queue not full, device addressed
    wfull = s_q.cnt[s_q.wq] == CNT_W'(DEPTH);
    do_wr = lnk.wr_en && s_q.wsel_me && !lnk.wr_sel_strobe && !wfull &&
            s_q.wdly == 2'(WR_OPEN_LAT - 1);                       // [R3]
    // read-port select; null queue behaves as empty
    if (lnk.rd_sel_strobe) begin
      // keep the old queue so its words still drain during the switch
      s_d.prq     = s_q.rq;
      s_d.prnull  = s_q.rnull;
      s_d.rnull   = lnk.rd_null_q;                                 // [R19]
      s_d.rq      = lnk.read_queue_select_bus[QSEL_LSB +: QSEL_W];
      s_d.rsel_me = lnk.rd_null_q ? s_q.rsel_me :
                    id_match(lnk.read_queue_select_bus, device_id_bit); // [R15]
      s_d.rdly    = 2'd0;
    end else if (s_q.rdly != 2'(RSEL_LAT - 1)) begin
      s_d.rdly = s_q.rdly + 2'd1;
    end
    // one-shot marker: the edge after this one is the hand-over edge
    s_d.rnew = !lnk.rd_sel_strobe && s_q.rdly == 2'(RSEL_LAT - 2);
    // pipeline keeps draining old queue until the new one takes over
    if (s_q.rdly == 2'(RSEL_LAT - 1)) begin
      fq     = s_q.rq;
      rempty = s_q.rnull || s_q.cnt[s_q.rq] == '0;                 // [R19]
    end else begin
      fq     = s_q.prq;
      rempty = s_q.prnull || s_q.cnt[s_q.prq] == '0;               // [R12]
    end
    // at hand-over the new word replaces the old one even if unread
    do_rd  = (lnk.rd_en || s_q.oval_n || s_q.rnew) && !rempty;
    // output register and its valid flag load together
    if (do_rd) begin
      s_d.dout   = s_q.mem[fq][s_q.rp[fq]];
      s_d.oval_n = 1'b0;                                           // [R10] [R20]
    end else if (lnk.rd_en || s_q.rnew) begin
      // old word stays put, but it no longer counts as valid
      s_d.oval_n = 1'b1;                                           // [R11] [R19]
    end
    // storage and per-queue counts, any queue on either port
    if (do_wr) begin
      s_d.mem[s_q.wq][s_q.wp[s_q.wq]] = lnk.wr_data;
      s_d.wp[s_q.wq] = s_q.wp[s_q.wq] + PTR_W'(1);
    end
    if (do_rd) s_d.rp[fq] = s_q.rp[fq] + PTR_W'(1);
    for (int i = 0; i < NQ; i++) begin
      if (do_wr && s_q.wq == QSEL_W'(i) && !(do_rd && fq == QSEL_W'(i)))
        s_d.cnt[i] = s_q.cnt[i] + CNT_W'(1);                       // [R14]
      else if (do_rd && fq == QSEL_W'(i) && !(do_wr && s_q.wq == QSEL_W'(i)))
        s_d.cnt[i] = s_q.cnt[i] - CNT_W'(1);                       // [R6]
    end
    // active full flag: new queue visible at second edge after select
    // frozen on the select edge and the one after it, so the old
    // queue status stands for exactly one more edge
    if (!lnk.wr_sel_strobe && s_q.wdly >= 2'(WSEL_LAT - 1))
      s_d.full_n = !(s_d.cnt[s_q.wq] == CNT_W'(DEPTH));            // [R1] [R2] [R8]
    // write window opens on the same edge the new full flag shows
    s_d.wrdy = s_d.wdly == 2'(WR_OPEN_LAT - 1) && s_d.wsel_me;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register the state; flags change only here
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_q         <= '0;                                           // [R5] [R13]
      s_q.full_n  <= FLAG_RST;
      s_q.oval_n  <= FLAG_RST;
      s_q.rnull   <= 1'b1;     // no queue picked yet: behave as null
      s_q.prnull  <= 1'b1;
      s_q.wdly    <= 2'(WR_OPEN_LAT - 1);
      s_q.rdly    <= 2'(RSEL_LAT - 1);
    end else begin
      s_q <= s_d;
    end
  end

  // tri-state enables follow the id match, no user control
  assign lnk.full_o    = s_q.full_n;
  assign lnk.full_oe   = s_q.wsel_me;                              // [R7] [R8]
  assign lnk.ovalid_o  = s_q.oval_n;
  assign lnk.ovalid_oe = s_q.rsel_me;                              // [R15] [R16]
  assign lnk.rd_data   = s_q.dout;
  assign lnk.wr_ready  = s_q.wrdy;
endmodule

// ---- pkg/mqsf_pkg.sv ----
// shared constants and types for the multi-queue status-flag link
package mqsf_pkg;
  localparam int QSEL_W       = 3;   // queue field of a select bus
  localparam int DEVID_W      = 3;   // device field of a select bus
  localparam int SEL_W        = QSEL_W + DEVID_W;
  localparam int NUM_QUEUES   = 8;
  localparam int DATA_W       = 18;
  localparam int QUEUE_DEPTH  = 4;   // words per queue
  localparam int PTR_W        = 2;
  localparam int CNT_W        = 3;
  localparam int WSEL_LAT     = 2;   // select edge to full flag of new queue
  localparam int WR_OPEN_LAT  = 3;   // select edge to first allowed write
  localparam int RSEL_LAT     = 3;   // select edge to new queue's first word
  localparam int QSEL_LSB     = 0;
  localparam int DEVID_LSB    = 3;
  localparam logic FLAG_RST   = 1'b1; // both flags read inactive after reset
  typedef logic [SEL_W-1:0]  mqsf_sel_t;
  typedef logic [DATA_W-1:0] mqsf_data_t;
endpackage

// ---- pkg/mqsf_if.sv ----
// link between the queue device and its system controller
`timescale 1ns/1ps
interface mqsf_if;
  import mqsf_pkg::*;
  logic       wr_sel_strobe;   // write_select_strobe
  logic [5:0] write_queue_select_bus;
  logic       wr_en;
  logic [17:0] wr_data;
  logic       wr_ready;
  logic       rd_sel_strobe;   // read_select_strobe
  logic [5:0] read_queue_select_bus;
  logic       rd_null_q;
  logic       rd_en;
  logic [17:0] rd_data;
  logic       full_o;
  logic       full_oe;
  logic       ovalid_o;
  logic       ovalid_oe;
  modport device (input wr_sel_strobe, write_queue_select_bus, wr_en, wr_data,
                  rd_sel_strobe, read_queue_select_bus, rd_null_q, rd_en,
                  output wr_ready, rd_data, full_o, full_oe, ovalid_o, ovalid_oe);
  modport ctrl (output wr_sel_strobe, write_queue_select_bus, wr_en, wr_data,
                rd_sel_strobe, read_queue_select_bus, rd_null_q, rd_en,
                input wr_ready, rd_data, full_o, full_oe, ovalid_o, ovalid_oe);
endinterface

// ---- design/mqsf_ctrl.sv ----
// controller end: selects queues, writes via a two-entry buffer, reads
`timescale 1ns/1ps
module mqsf_ctrl
  import mqsf_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire mqsf_pkg::mqsf_sel_t u_wsel,
  input  wire logic              u_wsel_go,
  input  wire mqsf_pkg::mqsf_sel_t u_rsel,
  input  wire logic              u_rnull,
  input  wire logic              u_rsel_go,
  input  wire mqsf_pkg::mqsf_data_t u_wdata,
  input  wire logic              u_wvalid,
  output logic                   u_wready,
  input  wire logic              u_rd,
  output mqsf_pkg::mqsf_data_t   u_rdata,
  output logic                   u_rvalid,
  mqsf_if.ctrl                   lnk
);
  import mqsf_pkg::*;

  typedef struct packed {
    logic [1:0][DATA_W-1:0] buf_d;
    logic [1:0]             cnt;
    logic                   wsel;
    mqsf_sel_t              wa;
    logic                   rsel;
    mqsf_sel_t              ra;
    logic                   rn;
    logic                   rd;
    mqsf_data_t             rdata;
    logic                   rvalid;
  } mqsf_ctl_st_t;

  mqsf_ctl_st_t s_q, s_d;
  logic         push, pop;

  ////////////////////////////////////////////////////////////////////////////
  // select strobes, buffer, and read capture
  always_comb begin
    s_d      = s_q;
    s_d.wsel = u_wsel_go;
    s_d.wa   = u_wsel_go ? u_wsel : s_q.wa;   // one device written at a time [R9]
    s_d.rsel = u_rsel_go;
    s_d.ra   = u_rsel_go ? u_rsel : s_q.ra;   // one device read at a time [R17]
    s_d.rn   = u_rsel_go && u_rnull;
    s_d.rd   = u_rd;
    // only drain when device ready and its shared full line says room
    pop  = s_q.cnt != 2'd0 && lnk.wr_ready && lnk.full_o && !s_q.wsel; // [R4]
    push = u_wvalid && s_q.cnt != 2'd2;
    if (pop) begin
      s_d.buf_d[0] = s_q.buf_d[1];
    end
    case ({push, pop})
      2'b10:   s_d.cnt = s_q.cnt + 2'd1;
      2'b01:   s_d.cnt = s_q.cnt - 2'd1;
      default: s_d.cnt = s_q.cnt;
    endcase
    if (push) s_d.buf_d[pop ? s_q.cnt - 2'd1 : s_q.cnt] = u_wdata;
    s_d.rdata  = lnk.rd_data;
    s_d.rvalid = lnk.ovalid_oe && !lnk.ovalid_o && s_q.rd;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (!resetn) s_q <= '0;
    else         s_q <= s_d;
  end

  // pop is sampled by the device this edge, so wr_en mirrors it
  assign lnk.wr_sel_strobe          = s_q.wsel;
  assign lnk.write_queue_select_bus = s_q.wa;
  assign lnk.wr_en                  = pop;
  assign lnk.wr_data                = s_q.buf_d[0];
  assign lnk.rd_sel_strobe          = s_q.rsel;
  assign lnk.read_queue_select_bus  = s_q.ra;
  assign lnk.rd_null_q              = s_q.rn;
  assign lnk.rd_en                  = s_q.rd;
  assign u_wready = s_q.cnt != 2'd2;
  assign u_rdata  = s_q.rdata;
  assign u_rvalid = s_q.rvalid;
endmodule

// ---- verif/mqsf_properties.sv ----
// link checker: write window, flag drive enables, reset idle levels
`timescale 1ns/1ps
module mqsf_properties #(
  parameter logic [2:0] DEV_ID = 3'h5
) (
  input wire logic       mclk,
  input wire logic       resetn,
  input wire logic       wr_sel_strobe,
  input wire logic [5:0] write_queue_select_bus,
  input wire logic       wr_en,
  input wire logic       wr_ready,
  input wire logic       rd_sel_strobe,
  input wire logic [5:0] read_queue_select_bus,
  input wire logic       rd_null_q,
  input wire logic       rd_en,
  input wire logic       full_o,
  input wire logic       full_oe,
  input wire logic       ovalid_o,
  input wire logic       ovalid_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // device field compare, upper three bits of each select bus
  wire wmine = write_queue_select_bus[5:3] == DEV_ID;
  wire rmine = read_queue_select_bus[5:3] == DEV_ID;
  sequence s_wpick;
    wr_sel_strobe;
  endsequence
  sequence s_wclosed;
    !wr_en [*2];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_select_closes_window: assert property (s_wpick |=> s_wclosed)
    else $error("write issued too soon after a write select");
  a_write_needs_window: assert property (wr_en |-> wr_ready)
    else $error("write outside the open window");
  a_write_not_full: assert property (wr_en |-> full_o)
    else $error("write while the active queue is full");
  a_full_drive_match: assert property (wr_sel_strobe && wmine |-> ##[0:2] full_oe)
    else $error("full flag not driven for own device");
  a_full_release_foreign: assert property (wr_sel_strobe && !wmine |-> ##[0:2] !full_oe)
    else $error("full flag driven for another device");
  a_valid_drive_match: assert property (rd_sel_strobe && !rd_null_q && rmine
    |-> ##[0:3] ovalid_oe)
    else $error("valid flag not driven for own device");
  a_valid_release_foreign: assert property (rd_sel_strobe && !rd_null_q && !rmine
    |-> ##[0:3] !ovalid_oe)
    else $error("valid flag driven for another device");
  // invalid only after an enabled read or a select a few edges back
  a_valid_rise_cause: assert property ($rose(ovalid_o) |-> $past(rd_en)
    || $past(rd_sel_strobe, 3) || $past(rd_sel_strobe, 4))
    else $error("valid flag went invalid with no read or select");
  a_reset_flags_idle: assert property (disable iff (1'b0) !resetn
    |=> full_o && ovalid_o && !full_oe && !ovalid_oe)
    else $error("flags not idle after reset");
endmodule

// ---- verif/multiqueue_active_status_flags_bench.sv ----
// bench joining device and controller ends, judging the link flags
`timescale 1ns/1ps
module multiqueue_active_status_flags_bench;
  import mqsf_pkg::*;
  localparam logic [2:0] DEV_ID = 3'h5;
  logic       mclk = 1'b0;
  logic       resetn = 1'b0;
  mqsf_sel_t  u_wsel = '0;
  mqsf_sel_t  u_rsel = '0;
  logic       u_wsel_go = 1'b0;
  logic       u_rsel_go = 1'b0;
  logic       u_rnull = 1'b0;
  logic       u_wvalid = 1'b0;
  logic       u_rd = 1'b0;
  mqsf_data_t u_wdata = '0;
  logic       u_wready;
  mqsf_data_t u_rdata;
  logic       u_rvalid;
  int         num_errors = 0;
  int         total_checks = 0;
  int         cycles = 0;
  always #5 mclk = ~mclk;
  mqsf_if lnk ();
  mqsf_device mqsf_device_inst (.mclk(mclk), .resetn(resetn), .device_id_bit(DEV_ID), .lnk(lnk));
  mqsf_ctrl mqsf_ctrl_inst (.mclk(mclk), .resetn(resetn), .u_wsel(u_wsel), .u_wsel_go(u_wsel_go),
    .u_rsel(u_rsel), .u_rnull(u_rnull), .u_rsel_go(u_rsel_go), .u_wdata(u_wdata),
    .u_wvalid(u_wvalid), .u_wready(u_wready), .u_rd(u_rd), .u_rdata(u_rdata),
    .u_rvalid(u_rvalid), .lnk(lnk));
  mqsf_properties #(.DEV_ID(DEV_ID)) mqsf_properties_inst (.mclk(mclk), .resetn(resetn),
    .wr_sel_strobe(lnk.wr_sel_strobe), .write_queue_select_bus(lnk.write_queue_select_bus),
    .wr_en(lnk.wr_en), .wr_ready(lnk.wr_ready), .rd_sel_strobe(lnk.rd_sel_strobe),
    .read_queue_select_bus(lnk.read_queue_select_bus), .rd_null_q(lnk.rd_null_q),
    .rd_en(lnk.rd_en), .full_o(lnk.full_o), .full_oe(lnk.full_oe),
    .ovalid_o(lnk.ovalid_o), .ovalid_oe(lnk.ovalid_oe));
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // hang guard, whole sequence needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      stop_test();
    end
  end
  // pulse a select; returns at the edge where the link takes it
  task automatic pick(input logic rd, input mqsf_sel_t sel, input logic nul);
    int n;
    n = 0;
    @(posedge mclk);
    {u_rsel_go, u_wsel_go} <= {rd, !rd};
    u_rsel <= sel;
    u_wsel <= sel;
    u_rnull <= nul;
    @(negedge mclk);
    while ((rd ? lnk.rd_sel_strobe : lnk.wr_sel_strobe) !== 1'b1 && n < 6) begin
      @(posedge mclk) {u_rsel_go, u_wsel_go} <= 2'b00;
      @(negedge mclk);
      n++;
    end
    if (n == 6) chk(1'b0, 1'b1);
    @(posedge mclk) {u_rsel_go, u_wsel_go} <= 2'b00;
  endtask
  // flag keeps old queue status until the fixed latency, then new one
  task automatic look(input logic rd, input mqsf_sel_t sel, input logic nul,
                      input logic old_f, input logic new_f);
    pick(rd, sel, nul);
    repeat (rd ? RSEL_LAT - 1 : WSEL_LAT - 1) @(posedge mclk);
    @(negedge mclk) chk(rd ? lnk.ovalid_o : lnk.full_o, old_f);
    @(posedge mclk);
    @(negedge mclk) chk(rd ? lnk.ovalid_o : lnk.full_o, new_f);
  endtask
  task automatic push(input int n, input mqsf_data_t base);
    for (int i = 0; i < n; i++) begin
      int k;
      k = 0;
      @(posedge mclk) u_wdata <= base + mqsf_data_t'(i);
      u_wvalid <= 1'b1;
      @(negedge mclk);
      while (u_wready !== 1'b1 && k < 20) begin
        @(negedge mclk);
        k++;
      end
    end
    @(posedge mclk) u_wvalid <= 1'b0;
  endtask
  // a word is consumed at an edge with read enable and valid low
  task automatic drain(input int n, input mqsf_data_t base);
    int k;
    int t;
    k = 0;
    t = 0;
    @(posedge mclk) u_rd <= 1'b1;
    while (k < n && t < 40) begin
      @(negedge mclk);
      t++;
      if (lnk.rd_en === 1'b1 && lnk.ovalid_o === 1'b0) begin
        chk(lnk.rd_data, base + mqsf_data_t'(k));
        k++;
      end
    end
    chk(k[17:0], n[17:0]);
    @(posedge mclk);
    @(negedge mclk) chk(lnk.ovalid_o, 1'b1);
    @(posedge mclk) u_rd <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    look(1'b0, {DEV_ID, 3'h0}, 1'b0, 1'b1, 1'b1);
    push(6, 18'h100);
    repeat (6) @(negedge mclk);
    chk(lnk.full_o, 1'b0);
    chk(u_wready, 1'b0); // two words parked, third refused
    chk(lnk.full_oe, 1'b1);
    look(1'b0, {DEV_ID, 3'h1}, 1'b0, 1'b0, 1'b1);
    repeat (8) @(negedge mclk);
    chk(u_wready, 1'b1);
    look(1'b0, {DEV_ID, 3'h0}, 1'b0, 1'b1, 1'b0);
    chk(lnk.full_oe, 1'b1);
    look(1'b0, {DEV_ID, 3'h1}, 1'b0, 1'b0, 1'b1);
    look(1'b1, {DEV_ID, 3'h0}, 1'b0, 1'b1, 1'b0);
    chk(lnk.rd_data, 18'h100);
    drain(4, 18'h100);
    look(1'b0, {DEV_ID, 3'h0}, 1'b0, 1'b1, 1'b1);
    look(1'b1, {DEV_ID, 3'h1}, 1'b0, 1'b1, 1'b0);
    drain(2, 18'h104);
    push(1, 18'h1aa);
    look(1'b1, {DEV_ID, 3'h0}, 1'b0, 1'b1, 1'b0);
    look(1'b1, 6'h00, 1'b1, 1'b0, 1'b1);
    chk(lnk.rd_data, 18'h1aa);
    pick(1'b0, {3'h2, 3'h1}, 1'b0);
    repeat (3) @(negedge mclk);
    chk(lnk.full_oe, 1'b0);
    pick(1'b1, {3'h2, 3'h1}, 1'b0);
    repeat (4) @(negedge mclk);
    chk(lnk.ovalid_oe, 1'b0);
    stop_test();
  end
endmodule
